// File: pkg/loop_det_pkg.sv
// constants, types and register map of the loop detector output and fault logic
package loop_det_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int AUX_PULSE_MS = 250;
  localparam int ENTRY_DELAY_MS = 2000;
  localparam int FLASH_HALF_MS = 250;
  localparam int BROWN_SLOTS = 2000 / FLASH_HALF_MS;
  localparam int SEQ_GAP_SLOTS = 4;
  localparam int REBASE_MS = 2000;
  localparam int REVIEW_HOLD_MS = 2000;
  localparam int HOLD_MIN_MS = 300_000;
  localparam int HOLD_MAX_MS = 10_800_000;
  localparam int FREQ_SHOW_MS = 4000;
  localparam int REVIEW_SHOW_MS = 5000;
  localparam logic [7:0] CHANGE_LIMIT_PCT = 8'h19;
  localparam logic [3:0] SENSITIVITY_BUTTON_MAX = 4'h9;
  localparam logic [3:0] BOOST_STEPS = 4'h2;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int FAILSAFE_BIT = 0;
  localparam int AUXMODE_LSB = 1;
  localparam int DELAY_BIT = 3;
  localparam int PRESENCE_BIT = 4;
  localparam int BOOST_BIT = 5;
  localparam int SENSITIVITY_BUTTON_LSB = 8;
  localparam logic [11:0] CTRL_RST = 12'h401;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_D = 7'h5e;
  localparam logic [6:0] SEG_F = 7'h71;

  typedef enum logic [1:0] {AUX_FAULT = 2'h0, AUX_EXIT = 2'h1, AUX_DUP = 2'h2,
    AUX_ENTRY = 2'h3} aux_mode_t;
  typedef enum logic [1:0] {FLT_NONE = 2'h0, FLT_OPEN = 2'h1, FLT_SHORT = 2'h2,
    FLT_SHIFT = 2'h3} fault_t;
  typedef enum logic [3:0] {DET_IDLE = 4'h1, DET_DELAY = 4'h2, DET_ACTIVE = 4'h4,
    DET_EXPIRED = 4'h8} det_state_t;

  typedef struct packed {
    logic vehicle;
    logic faultOpen;
    logic faultShort;
    logic [7:0] shiftPct;
    logic [7:0] freqKhz;
    logic [3:0] strength;
  } loop_in_t;

  typedef struct packed {
    det_state_t det;
    logic [23:0] timer;
    logic [16:0] msCnt;
    logic [7:0] slotMs;
    logic [3:0] seqSlot;
    logic [2:0] freeSlot;
    logic [7:0] pulseMs;
    logic [10:0] btnMs;
    logic btnHeld;
    logic [11:0] rebaseMs;
    logic shiftFault;
    logic [12:0] showMs;
    logic showFreq;
    logic showReview;
    fault_t lastFault;
    logic loadPend;
    logic [11:0] ctrl;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic presence;
    logic aux;
    logic red;
    logic green;
    logic [6:0] seg;
    logic boost;
    logic [3:0] sensEff;
    logic rebase;
    logic nvWrite;
  } st_t;
endpackage : loop_det_pkg

// File: rtl/loop_det_core.sv
// output, timing and fault indication logic of a single-channel loop detector
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module loop_det_core
  import loop_det_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int HOLD_MS = HOLD_MIN_MS
) (
  input wire logic clock, // 125 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire loop_in_t loopIn, // loop front end indications
  input wire fault_t nvFaultIn, // stored loop status from non-volatile memory
  input wire logic prevCallIn, // call was active before a short supply gap
  input wire logic brownOut, // supply insufficient
  input wire logic resetButton, // front reset button, high while pressed
  output logic presenceOut, // output A, presence
  output logic auxOut, // output B
  output logic auxInvOut, // output B inverted
  output logic redLed, // output indicator
  output logic greenLed, // power and fault indicator
  output logic [6:0] seg7, // display segments gfedcba
  output logic boostActive, // sensitivity boost in force
  output logic [3:0] sensEffective, // sensitivity level to the front end
  output logic rebaseReq, // pulse: adopt present inductance as reference
  output fault_t nvFaultOut, // loop status to store
  output logic nvWrite // pulse: store nvFaultOut
);
  st_t s;
  st_t n;
  fault_t faultNow;
  logic msTick;
  logic slotTick;
  logic [3:0] seqLen;
  logic seqOn;
  logic presNom;
  logic softRst;

  // segment pattern for one decimal digit
  function automatic logic [6:0] seg_digit(input logic [3:0] d);
    case (d)
      4'h0: seg_digit = 7'h3f;
      4'h1: seg_digit = 7'h06;
      4'h2: seg_digit = 7'h5b;
      4'h3: seg_digit = 7'h4f;
      4'h4: seg_digit = 7'h66;
      4'h5: seg_digit = 7'h6d;
      4'h6: seg_digit = 7'h7d;
      4'h7: seg_digit = 7'h07;
      4'h8: seg_digit = 7'h7f;
      4'h9: seg_digit = 7'h6f;
      default: seg_digit = SEG_BLANK;
    endcase
  endfunction : seg_digit

  // fault classification, open before short before shift
  assign faultNow = loopIn.faultOpen ? FLT_OPEN : loopIn.faultShort ? FLT_SHORT :
                    s.shiftFault ? FLT_SHIFT : FLT_NONE;
  assign msTick = (s.msCnt == 17'(MS_CYC - 1));
  assign slotTick = msTick && (s.slotMs == 8'(FLASH_HALF_MS - 1));
  // flash sequence: code flashes of one slot on, one off, then a gap
  assign seqLen = (faultNow != FLT_NONE) ? {1'b0, faultNow, 1'b0} : {1'b0, s.lastFault, 1'b0};
  assign seqOn = (s.seqSlot < seqLen) && !s.seqSlot[0];
  assign presNom = (s.det == DET_ACTIVE);
  assign softRst = s.btnHeld && !resetButton && (s.btnMs < 11'(REVIEW_HOLD_MS));

  // next-state logic
  always_comb begin
    n = s;
    n.rebase = 1'b0;
    n.nvWrite = 1'b0;
    // millisecond and flash slot dividers
    n.msCnt = msTick ? 17'h0 : s.msCnt + 17'h1;
    if (msTick) begin
      n.slotMs = slotTick ? 8'h0 : s.slotMs + 8'h1;
    end
    if (slotTick) begin
      n.freeSlot = s.freeSlot + 3'h1;
      n.seqSlot = (s.seqSlot >= seqLen + 4'(SEQ_GAP_SLOTS - 1)) ? 4'h0 : s.seqSlot + 4'h1;
    end
    // excessive change detection and re-reference after two seconds
    if (!s.shiftFault && loopIn.shiftPct > CHANGE_LIMIT_PCT) begin
      n.shiftFault = 1'b1;
      n.rebaseMs = 12'h0;
    end else if (s.shiftFault && msTick) begin
      if (s.rebaseMs == 12'(REBASE_MS - 1)) begin
        n.shiftFault = 1'b0;
        n.rebase = 1'b1;
      end else begin
        n.rebaseMs = s.rebaseMs + 12'h1;
      end
    end
    // aux pulse timer
    if (msTick && s.pulseMs != 8'h0) begin
      n.pulseMs = s.pulseMs - 8'h1;
    end
    // detector state machine
    if (msTick) begin
      n.timer = s.timer + 24'h1;
    end
    case (s.det)
      DET_IDLE: begin
        if (loopIn.vehicle) begin
          n.timer = 24'h0;
          if (s.ctrl[DELAY_BIT]) begin
            n.det = DET_DELAY;
          end else begin
            n.det = DET_ACTIVE;
          end
        end
      end
      DET_DELAY: begin
        if (!loopIn.vehicle) begin
          n.det = DET_IDLE;
        end else if (msTick && s.timer == 24'(ENTRY_DELAY_MS - 1)) begin
          n.det = DET_ACTIVE;
          n.timer = 24'h0;
        end
      end
      DET_ACTIVE: begin
        if (!loopIn.vehicle) begin
          n.det = DET_IDLE;
        end else if (s.ctrl[PRESENCE_BIT] && msTick && s.timer == 24'(HOLD_MS - 1)) begin
          n.det = DET_EXPIRED;
        end
      end
      DET_EXPIRED: begin
        if (!loopIn.vehicle) begin
          n.det = DET_IDLE;
        end
      end
      default: n.det = DET_IDLE;
    endcase
    // a call remembered across a short supply gap skips the entry delay
    if (s.loadPend) begin
      n.loadPend = 1'b0;
      n.lastFault = nvFaultIn;
      if (prevCallIn && loopIn.vehicle) begin
        n.det = DET_ACTIVE;
        n.timer = 24'h0;
      end
    end
    // aux pulses on entry and exit
    if (n.det == DET_ACTIVE && s.det != DET_ACTIVE && aux_mode_t'(s.ctrl[2:1]) == AUX_ENTRY) begin
      n.pulseMs = 8'(AUX_PULSE_MS);
    end
    if (n.det == DET_IDLE && (s.det == DET_ACTIVE || s.det == DET_EXPIRED) &&
        aux_mode_t'(s.ctrl[2:1]) == AUX_EXIT) begin
      n.pulseMs = 8'(AUX_PULSE_MS);
    end
    // reset button: short press resets, long hold reviews the stored fault
    n.btnHeld = resetButton;
    if (resetButton) begin
      if (!s.btnHeld) begin
        n.btnMs = 11'h0;
      end else if (msTick && s.btnMs < 11'(REVIEW_HOLD_MS)) begin
        n.btnMs = s.btnMs + 11'h1;
        if (s.btnMs == 11'(REVIEW_HOLD_MS - 1)) begin
          n.showReview = 1'b1;
          n.showFreq = 1'b0;
          n.showMs = 13'h0;
        end
      end
    end
    if (softRst) begin
      n.det = DET_IDLE;
      n.pulseMs = 8'h0;
      n.lastFault = FLT_NONE;
      n.showFreq = 1'b1;
      n.showReview = 1'b0;
      n.showMs = 13'h0;
      n.seqSlot = 4'h0;
    end
    if (msTick && (s.showFreq || s.showReview)) begin
      n.showMs = s.showMs + 13'h1;
      if (s.showFreq && s.showMs == 13'(FREQ_SHOW_MS - 1)) begin
        n.showFreq = 1'b0;
      end
      if (s.showReview && s.showMs == 13'(REVIEW_SHOW_MS - 1)) begin
        n.showReview = 1'b0;
      end
    end
    // a fault seen in the clearing cycle still gets stored
    if (faultNow != FLT_NONE) begin
      n.lastFault = faultNow;
    end
    n.nvWrite = (n.lastFault != s.lastFault);
    // outputs
    n.presence = (s.ctrl[FAILSAFE_BIT] && faultNow != FLT_NONE) ? 1'b1 : presNom;
    case (aux_mode_t'(s.ctrl[2:1]))
      AUX_FAULT: n.aux = (faultNow != FLT_NONE);
      AUX_DUP: n.aux = n.presence;
      default: n.aux = (s.pulseMs != 8'h0);
    endcase
    n.boost = s.ctrl[BOOST_BIT] && presNom;
    if (n.boost) begin
      n.sensEff = (s.ctrl[11:8] + BOOST_STEPS > SENSITIVITY_BUTTON_MAX) ? SENSITIVITY_BUTTON_MAX : s.ctrl[11:8] + BOOST_STEPS;
    end else begin
      n.sensEff = s.ctrl[11:8];
    end
    // indicators
    if (faultNow != FLT_NONE) begin
      n.red = seqOn;
    end else if (s.det == DET_DELAY) begin
      n.red = s.freeSlot[0];
    end else begin
      n.red = presNom;
    end
    if (faultNow != FLT_NONE || s.lastFault != FLT_NONE) begin
      n.green = seqOn;
    end else if (brownOut) begin
      n.green = (s.freeSlot == 3'(BROWN_SLOTS - 1));
    end else begin
      n.green = 1'b1;
    end
    // display, first and second character alternate every two slots
    if (s.showReview) begin
      n.seg = s.freeSlot[1] ? seg_digit({2'h0, s.lastFault}) : SEG_F;
    end else if (faultNow != FLT_NONE) begin
      n.seg = s.freeSlot[1] ? seg_digit({2'h0, faultNow}) : SEG_F;
    end else if (s.det == DET_DELAY) begin
      n.seg = SEG_D;
    end else if (s.showFreq) begin
      n.seg = s.freeSlot[1] ? seg_digit(4'(loopIn.freqKhz % 8'd10)) :
                              seg_digit(4'(loopIn.freqKhz / 8'd10));
    end else begin
      n.seg = seg_digit(loopIn.strength);
    end
    // register bus, write path
    if (awvalid && !s.awHave) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && !s.wHave) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (s.awHave && s.wHave && !s.bValid) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = RESP_OKAY;
      if (s.awAddr == CTRL_OFS) begin
        if (s.wStrb[0]) begin
          n.ctrl[7:0] = s.wData[7:0];
        end
        if (s.wStrb[1]) begin
          n.ctrl[11:8] = (s.wData[11:8] > SENSITIVITY_BUTTON_MAX) ? SENSITIVITY_BUTTON_MAX : s.wData[11:8];
        end
      end else if (s.awAddr != STATUS_OFS) begin
        n.bResp = RESP_SLVERR;
      end
    end
    if (s.bValid && bready) begin
      n.bValid = 1'b0;
    end
    // register bus, read path
    if (arvalid && !s.rValid) begin
      n.rValid = 1'b1;
      n.rResp = RESP_OKAY;
      n.rData = 32'h0;
      if (araddr == CTRL_OFS) begin
        n.rData = {20'h0, s.ctrl};
      end else if (araddr == STATUS_OFS) begin
        n.rData = {19'h0, s.boost, s.showFreq, s.showReview, s.lastFault, faultNow,
                   s.det, s.aux, s.presence};
      end else begin
        n.rResp = RESP_SLVERR;
      end
    end else if (s.rValid && rready) begin
      n.rValid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      s <= '0;
      s.det <= DET_IDLE;
      s.lastFault <= FLT_NONE;
      s.loadPend <= 1'b1;
      s.showFreq <= 1'b1;
      s.ctrl <= CTRL_RST;
      s.sensEff <= CTRL_RST[11:8];
    end else begin
      s <= n;
    end
  end

  assign awready = !s.awHave;
  assign wready = !s.wHave;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = !s.rValid;
  assign rvalid = s.rValid;
  assign rdata = s.rData;
  assign rresp = s.rResp;
  assign presenceOut = s.presence;
  assign auxOut = s.aux;
  assign auxInvOut = !s.aux;
  assign redLed = s.red;
  assign greenLed = s.green;
  assign seg7 = s.seg;
  assign boostActive = s.boost;
  assign sensEffective = s.sensEff;
  assign rebaseReq = s.rebase;
  assign nvFaultOut = s.lastFault;
  assign nvWrite = s.nvWrite;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_aux_inv;
    auxInvOut == !auxOut;
  endproperty
  a_aux_inv: assert property (p_aux_inv) else $error("aux inverse mismatch");

  property p_aux_fault;
    (s.ctrl[2:1] == AUX_FAULT && faultNow != FLT_NONE) |=> auxOut;
  endproperty
  a_aux_fault: assert property (p_aux_fault) else $error("aux not on for fault");

  property p_aux_dup;
    (s.ctrl[2:1] == AUX_DUP && $past(s.ctrl[2:1]) == AUX_DUP) |-> auxOut == presenceOut;
  endproperty
  a_aux_dup: assert property (p_aux_dup) else $error("aux not duplicating A");

  property p_entry_pulse;
    (s.det == DET_ACTIVE && $past(s.det) != DET_ACTIVE && $past(s.ctrl[2:1]) == AUX_ENTRY
     && !$past(softRst)) |-> s.pulseMs == 8'(AUX_PULSE_MS) ##1 auxOut;
  endproperty
  a_entry_pulse: assert property (p_entry_pulse) else $error("entry pulse missing");

  property p_fail_safe;
    (s.ctrl[FAILSAFE_BIT] && faultNow != FLT_NONE) |=> presenceOut;
  endproperty
  a_fail_safe: assert property (p_fail_safe) else $error("fail-safe not forcing A");

  property p_delay_abandon;
    (s.det == DET_DELAY && !loopIn.vehicle) |=> s.det == DET_IDLE ##1 !presNom;
  endproperty
  a_delay_abandon: assert property (p_delay_abandon) else $error("delay not abandoned");

  property p_delay_disp;
    (s.det == DET_DELAY && faultNow == FLT_NONE && !s.showReview) |=> seg7 == SEG_D;
  endproperty
  a_delay_disp: assert property (p_delay_disp) else $error("delay letter missing");

  property p_red_detect;
    (presNom && faultNow == FLT_NONE) |=> redLed;
  endproperty
  a_red_detect: assert property (p_red_detect) else $error("red not steady");

  property p_fault_store;
    (faultNow != FLT_NONE) |=> nvFaultOut == $past(faultNow);
  endproperty
  a_fault_store: assert property (p_fault_store) else $error("fault not stored");

  property p_shift_class;
    (loopIn.shiftPct > CHANGE_LIMIT_PCT && !s.shiftFault) |=> s.shiftFault;
  endproperty
  a_shift_class: assert property (p_shift_class) else $error("shift not classed");

  c_delay_done: cover property (s.det == DET_DELAY ##1 s.det == DET_ACTIVE);
  c_exit_pulse: cover property (s.ctrl[2:1] == AUX_EXIT && $rose(auxOut));
  c_review: cover property ($rose(s.showReview));
  c_fault: cover property ($rose(rebaseReq) && !s.shiftFault);
endmodule : loop_det_core
`default_nettype wire

// File: dv/gate_model.sv
// gate-side model that times output B pulses and watches the output B pair
`timescale 1ns/1ns
`default_nettype none
module gate_model (
  input wire logic clock, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic auxOut, // output B from the detector
  input wire logic auxInvOut, // output B inverted
  output logic [15:0] pulseLen, // length in cycles of the last finished output B pulse
  output logic [7:0] pulseCnt, // count of finished output B pulses
  output logic pairBad // output B pair was once not complementary
);
  logic [15:0] runLen;
  // time every high period of output B and note any broken complement
  always_ff @(posedge clock) begin
    if (srst) begin
      runLen <= 16'h0000;
      pulseLen <= 16'h0000;
      pulseCnt <= 8'h00;
      pairBad <= 1'b0;
    end else begin
      runLen <= auxOut ? runLen + 16'h0001 : 16'h0000;
      if (!auxOut && runLen != 16'h0000) begin
        pulseLen <= runLen;
        pulseCnt <= pulseCnt + 8'h01;
      end
      if (auxOut === auxInvOut) pairBad <= 1'b1;
    end
  end
endmodule : gate_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking testbench of the loop detector output and fault logic
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import loop_det_pkg::*;
  localparam int MSC = 4;
  localparam int HOLD = 20;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, presenceOut, auxOut, auxInvOut;
  logic redLed, greenLed, boostActive, rebaseReq, nvWrite, pairBad;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] seg7;
  logic [3:0] sensEffective;
  logic [15:0] pulseLen;
  logic [7:0] pulseCnt;
  fault_t nvFaultOut;
  fault_t nvIn = FLT_NONE;
  logic button = 1'b0, brown = 1'b0, prevCall = 1'b0;
  loop_in_t loopIn = '{vehicle: 1'b0, faultOpen: 1'b0, faultShort: 1'b0, shiftPct: 8'h00,
    freqKhz: 8'h2a, strength: 4'h0};
  int num_errors = 0;
  int samples_checked = 0;

  always #4 clock = ~clock;

  loop_det_core #(.MS_CYC(MSC), .HOLD_MS(HOLD)) dut (.clock(clock), .srst(srst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .loopIn(loopIn), .nvFaultIn(nvIn),
    .prevCallIn(prevCall), .brownOut(brown), .resetButton(button), .presenceOut(presenceOut),
    .auxOut(auxOut), .auxInvOut(auxInvOut), .redLed(redLed), .greenLed(greenLed),
    .seg7(seg7), .boostActive(boostActive), .sensEffective(sensEffective),
    .rebaseReq(rebaseReq), .nvFaultOut(nvFaultOut), .nvWrite(nvWrite));

  gate_model gate (.clock(clock), .srst(srst), .auxOut(auxOut), .auxInvOut(auxInvOut),
    .pulseLen(pulseLen), .pulseCnt(pulseCnt), .pairBad(pairBad));

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // compare one value against its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // bus write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200) begin
      num_errors++;
      test_done();
    end
    chk(bresp, er);
    cyc(1);
  endtask : wr

  // bus read, address released once taken, ready held until the answer is sampled
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    if (n >= 200) begin
      num_errors++;
      test_done();
    end
    chk(rresp, er);
    if (er === RESP_OKAY) chk(rdata, ed);
    cyc(1);
  endtask : rd

  // defaults, clamping of the level and an unmapped place
  task automatic t_regs();
    rd(CTRL_OFS, 32'h401, RESP_OKAY);
    wr(CTRL_OFS, 32'hf01, RESP_OKAY);
    rd(CTRL_OFS, 32'h901, RESP_OKAY);
    wr(8'h10, 32'h0, RESP_SLVERR);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(CTRL_OFS, 32'h401, RESP_OKAY);
  endtask : t_regs

  // open loop fault with fail-safe or fail-secure selected
  task automatic t_fault(input logic fs);
    wr(CTRL_OFS, {31'h200, fs}, RESP_OKAY);
    loopIn.faultOpen <= 1'b1;
    cyc(6);
    chk(auxOut, 1'b1);
    chk(auxInvOut, 1'b0);
    chk(presenceOut, fs);
    chk(seg7 == SEG_F || seg7 == 7'h06, 1);
    loopIn.faultOpen <= 1'b0;
    cyc(6);
    chk(auxOut, 1'b0);
    chk(presenceOut, 1'b0);
    chk(nvFaultOut, FLT_OPEN);
  endtask : t_fault

  // output B pulse on exit or entry, 249 to 250 ms long
  task automatic t_pulse(input logic entry);
    logic [7:0] c0;
    wr(CTRL_OFS, entry ? 32'h407 : 32'h403, RESP_OKAY);
    c0 = pulseCnt;
    loopIn.vehicle <= 1'b1;
    cyc(1100);
    chk(presenceOut, 1'b1);
    chk(pulseCnt - c0, entry);
    loopIn.vehicle <= 1'b0;
    cyc(1100);
    chk(pulseCnt - c0, 1);
    chk(pulseLen >= 249 * MSC && pulseLen <= 250 * MSC, 1);
    chk(pairBad, 1'b0);
  endtask : t_pulse

  // output B duplicates output A
  task automatic t_dup();
    wr(CTRL_OFS, 32'h405, RESP_OKAY);
    loopIn.vehicle <= 1'b1;
    cyc(6);
    chk(auxOut, presenceOut);
    chk(auxOut, 1'b1);
    loopIn.vehicle <= 1'b0;
    cyc(6);
    chk(auxOut, 1'b0);
  endtask : t_dup

  // entry delay held to the end, then abandoned half way
  task automatic t_delay();
    logic r1;
    wr(CTRL_OFS, 32'h409, RESP_OKAY);
    loopIn.vehicle <= 1'b1;
    cyc(100);
    chk(seg7, SEG_D);
    r1 = redLed;
    cyc(1000);
    chk(redLed !== r1, 1);
    cyc(6800);
    chk(presenceOut, 1'b0);
    cyc(120);
    chk(presenceOut, 1'b1);
    chk(redLed, 1'b1);
    loopIn.vehicle <= 1'b0;
    cyc(6);
    loopIn.vehicle <= 1'b1;
    cyc(4000);
    loopIn.vehicle <= 1'b0;
    cyc(4200);
    chk(presenceOut, 1'b0);
  endtask : t_delay

  // limited presence drops after the hold, infinite presence keeps it
  task automatic t_hold(input logic lim);
    wr(CTRL_OFS, lim ? 32'h411 : 32'h401, RESP_OKAY);
    loopIn.vehicle <= 1'b1;
    cyc(HOLD * MSC + 40);
    chk(presenceOut, !lim);
    loopIn.vehicle <= 1'b0;
    cyc(6);
  endtask : t_hold

  // sensitivity boost during detection only
  task automatic t_boost();
    wr(CTRL_OFS, 32'h421, RESP_OKAY);
    loopIn.vehicle <= 1'b1;
    cyc(6);
    chk(boostActive, 1'b1);
    chk(sensEffective, 4'h6);
    loopIn.vehicle <= 1'b0;
    cyc(6);
    chk(sensEffective, 4'h4);
  endtask : t_boost

  // shift fault classed, then re-referenced once after two seconds
  task automatic t_shift();
    int k;
    k = 0;
    wr(CTRL_OFS, 32'h401, RESP_OKAY);
    loopIn.shiftPct <= 8'h30;
    cyc(2);
    loopIn.shiftPct <= 8'h00;
    cyc(6);
    chk(nvFaultOut, FLT_SHIFT);
    chk(auxOut, 1'b1);
    repeat (2100 * MSC) begin
      @(posedge clock);
      if (rebaseReq === 1'b1) k++;
    end
    chk(k, 1);
    chk(auxOut, 1'b0);
    chk(nvFaultOut, FLT_SHIFT);
  endtask : t_shift

  // long hold reviews, short press clears, then brown-out blink
  task automatic t_button();
    int g;
    g = 0;
    button <= 1'b1;
    cyc(2000 * MSC + 40);
    chk(seg7 == SEG_F || seg7 == 7'h4f, 1);
    button <= 1'b0;
    cyc(4);
    chk(nvFaultOut, FLT_SHIFT);
    button <= 1'b1;
    cyc(20);
    button <= 1'b0;
    cyc(4);
    chk(nvFaultOut, FLT_NONE);
    chk(seg7 == 7'h66 || seg7 == 7'h5b, 1);
    brown <= 1'b1;
    cyc(4);
    repeat (8 * FLASH_HALF_MS * MSC) begin
      @(posedge clock);
      if (greenLed === 1'b1) g++;
    end
    chk(g, FLASH_HALF_MS * MSC);
    brown <= 1'b0;
    cyc(2);
  endtask : t_button

  // supply gap: reset in mid-run with a stored fault and a remembered call
  task automatic t_power();
    nvIn <= FLT_SHORT;
    prevCall <= 1'b1;
    loopIn.vehicle <= 1'b1;
    srst <= 1'b1;
    cyc(4);
    srst <= 1'b0;
    cyc(4);
    chk(presenceOut, 1'b1);
    chk(nvFaultOut, FLT_SHORT);
    loopIn.vehicle <= 1'b0;
    prevCall <= 1'b0;
    cyc(6);
  endtask : t_power

  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    cyc(4);
    t_regs();
    t_fault(1'b1);
    t_fault(1'b0);
    t_pulse(1'b0);
    t_pulse(1'b1);
    t_dup();
    t_delay();
    t_hold(1'b0);
    t_hold(1'b1);
    t_boost();
    t_shift();
    t_button();
    t_power();
    test_done();
  end
endmodule : testbench
`default_nettype wire
